// [design/fpmc_menu_ctrl.sv]
// front-panel menu controller: buttons, encoder, screens, set-point editing
// assumes an AHB-Lite master with hready looped from hreadyout, and an
// external nonvolatile store that takes nvmData on each nvmWrite pulse
`timescale 1ns/1ps
// Overview of operation
// - set points only scale output; operating limits stay 0-63 kHz, -11..+11 V.
// - reset restores all defaults including both trims, dropping stored values.
// - display press over one second opens secondary screens; short press steps primaries.
// - contrast screen returns after twenty seconds idle, two shorts, or long press.
// - on contrast screen, counterclockwise lightens, clockwise darkens.
// - entering an editable screen puts the blinking cursor on top-left character.
// - encoder push advances cursor to next editable character, wrapping to first.
// - rotation increments or decrements digit under cursor with carry and borrow.
// - steps that would leave permitted limits are refused, value unchanged.
// - long encoder push on alignment screen opens reset; Yes plus push resets.
// - changed parameters are stored only when operate screen is restored.
// - operate screen at power-up; zeroes below 1 Hz, dashes above 63 kHz.
// - operate screen shows full frequency and per-revolution filter indicator with setting.
// - one short press reaches frequency set; seven more or twenty seconds return.
// - defaults 50000/0 Hz; upper confined 10-50000, lower 0-49990 Hz.
// - frequency screen has ten digits; cursor starts on upper ten-thousands digit.
// - edits bringing upper and lower within 10 Hz of each other are refused.
module fpmc_menu_ctrl #(
	parameter int LONG_CYC = fpmc_pkg::LONG_PRESS_MS * fpmc_pkg::CLK_PER_MS,
	parameter int IDLE_CYC = fpmc_pkg::IDLE_RETURN_MS * fpmc_pkg::CLK_PER_MS,
	parameter int DEBOUNCE_CYC = fpmc_pkg::DEBOUNCE_MS * fpmc_pkg::CLK_PER_MS,
	parameter int BLINK_CYC = fpmc_pkg::BLINK_MS * fpmc_pkg::CLK_PER_MS
) (
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// front panel, active high while pressed
	input wire logic dispBtn,
	input wire logic encBtn,
	input wire logic encA,
	input wire logic encB,
	// measurement
	input wire logic [16:0] measFreqHz,
	// display side
	output fpmc_pkg::fpmc_screen_t screen,
	output logic [3:0] cursor,
	output logic cursorBlink,
	output logic resetYes,
	output fpmc_pkg::fpmc_opmode_t operMode,
	output logic [16:0] operFreqHz,
	output logic per_rev_filter_indicator,
	output logic [9:0] perRevCount,
	output fpmc_pkg::fpmc_settings_t settings,
	// nonvolatile store
	output logic nvmWrite,
	output fpmc_pkg::fpmc_settings_t nvmData
);
	import fpmc_pkg::*;

	// -------------------------------------------------------------
	// debounce
	// -------------------------------------------------------------
	logic [3:0] raw;
	logic [3:0] clean_q;
	logic [3:0] clean_d;
	logic [3:0] prev_q;
	logic [31:0] dbCnt_q [4];
	logic [31:0] dbCnt_d [4];
	assign raw = {encB, encA, encBtn, dispBtn};

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_db
			always_comb begin
				clean_d[gi] = clean_q[gi];
				dbCnt_d[gi] = 32'h0;
				if (raw[gi] != clean_q[gi]) begin
					dbCnt_d[gi] = dbCnt_q[gi] + 32'h1;
					if (dbCnt_q[gi] >= 32'(DEBOUNCE_CYC - 1)) begin
						clean_d[gi] = raw[gi];
						dbCnt_d[gi] = 32'h0;
					end
				end
			end
			always_ff @(posedge clk or negedge resetn) begin
				if (!resetn) begin
					clean_q[gi] <= 1'b0;
					prev_q[gi] <= 1'b0;
					dbCnt_q[gi] <= 32'h0;
				end else begin
					clean_q[gi] <= clean_d[gi];
					prev_q[gi] <= clean_q[gi];
					dbCnt_q[gi] <= dbCnt_d[gi];
				end
			end
		end
	endgenerate

	// -------------------------------------------------------------
	// press classification: index 0 display, 1 encoder
	// -------------------------------------------------------------
	logic [31:0] hold_q [2];
	logic [31:0] hold_d [2];
	logic [1:0] shortEv;
	logic [1:0] longEv;

	generate
		for (gi = 0; gi < 2; gi++) begin : g_press
			always_comb begin
				hold_d[gi] = 32'h0;
				if (clean_q[gi])
					hold_d[gi] = (hold_q[gi] >= 32'(LONG_CYC)) ? hold_q[gi] : hold_q[gi] + 32'h1;
				longEv[gi] = clean_q[gi] && hold_q[gi] == 32'(LONG_CYC - 1);
				shortEv[gi] = !clean_q[gi] && prev_q[gi] && hold_q[gi] < 32'(LONG_CYC);
			end
			always_ff @(posedge clk or negedge resetn) begin
				if (!resetn)
					hold_q[gi] <= 32'h0;
				else
					hold_q[gi] <= hold_d[gi];
			end
		end
	endgenerate

	logic stepCw;
	logic stepCcw;
	logic activity;
	// one step per detent, taken on the rising edge of channel A
	assign stepCw = clean_q[2] && !prev_q[2] && !clean_q[3];
	assign stepCcw = clean_q[2] && !prev_q[2] && clean_q[3];
	assign activity = clean_q != prev_q;

	// -------------------------------------------------------------
	// menu state
	// -------------------------------------------------------------
	fpmc_screen_t scr_q, scr_d;
	logic [3:0] cur_q, cur_d;
	fpmc_settings_t set_q, set_d, nvmData_q, nvmData_d;
	logic dirty_q, dirty_d, yes_q, yes_d, nvmWr_q, nvmWr_d;
	logic [31:0] idle_q, idle_d;

	function automatic logic [17:0] digitWeight(input logic [3:0] pos);
		case (pos)
			4'h0, 4'h5: digitWeight = 18'h02710;
			4'h1, 4'h6: digitWeight = 18'h003E8;
			4'h2, 4'h7: digitWeight = 18'h00064;
			4'h3, 4'h8: digitWeight = 18'h0000A;
			default: digitWeight = 18'h00001;
		endcase
	endfunction : digitWeight

	logic isUpper, goOperate, borrow, okF;
	logic [17:0] w, base, cand, upIn, loIn;
	logic signed [10:0] trimCur, trimNew;

	always_comb begin
		scr_d = scr_q;
		cur_d = cur_q;
		set_d = set_q;
		dirty_d = dirty_q;
		yes_d = yes_q;
		nvmWr_d = 1'b0;
		nvmData_d = nvmData_q;
		goOperate = 1'b0;
		isUpper = cur_q < UPPER_DIGITS;
		w = digitWeight(cur_q);
		upIn = {2'b00, set_q.fUpper};
		loIn = {2'b00, set_q.fLower};
		base = isUpper ? upIn : loIn;
		borrow = stepCcw && base < w;
		cand = stepCw ? base + w : base - w;
		if (isUpper)
			okF = cand >= F_UPPER_MIN && cand <= F_UPPER_MAX && cand >= loIn + F_GAP;
		else
			okF = !borrow && cand <= F_LOWER_MAX && cand + F_GAP <= upIn;
		trimCur = cur_q[0] ? set_q.trimHi : set_q.trimLo;
		trimNew = stepCw ? trimCur + 11'sh001 : trimCur - 11'sh001;
		idle_d = (activity || scr_q == SCR_OPERATE) ? 32'h0 : idle_q + 32'h1;
		case (scr_q)
			SCR_OPERATE: begin
				if (shortEv[0])
					scr_d = SCR_FREQ;
				else if (longEv[0])
					scr_d = SCR_CONTRAST;
			end
			SCR_FREQ, SCR_VOLT, SCR_PULSES, SCR_SENS, SCR_BW, SCR_OUTFILT, SCR_CAL: begin
				if (shortEv[0]) begin
					if (scr_q == SCR_CAL)
						goOperate = 1'b1;
					else
						scr_d = fpmc_screen_t'(scr_q + 4'h1);
				end else if (longEv[0])
					scr_d = SCR_CONTRAST;
				if (scr_q == SCR_FREQ) begin
					if (shortEv[1])
						cur_d = (cur_q == FREQ_LAST_POS) ? 4'h0 : cur_q + 4'h1;
					// a refused step leaves the value alone
					if ((stepCw || stepCcw) && okF) begin
						dirty_d = 1'b1;
						if (isUpper)
							set_d.fUpper = cand[15:0];
						else
							set_d.fLower = cand[15:0];
					end
				end
			end
			SCR_CONTRAST: begin
				if (shortEv[0])
					scr_d = SCR_ALIGN;
				else if (longEv[0])
					goOperate = 1'b1;
				if (stepCw && set_q.contrast != CONTRAST_MAX) begin
					set_d.contrast = set_q.contrast + 6'h01;
					dirty_d = 1'b1;
				end else if (stepCcw && set_q.contrast != 6'h00) begin
					set_d.contrast = set_q.contrast - 6'h01;
					dirty_d = 1'b1;
				end
			end
			SCR_ALIGN: begin
				if (shortEv[0] || longEv[0])
					goOperate = 1'b1;
				else if (longEv[1]) begin
					scr_d = SCR_RESET;
					yes_d = 1'b0;
				end else if (shortEv[1])
					cur_d = {3'b000, !cur_q[0]};
				if ((stepCw || stepCcw) && trimNew <= TRIM_MAX && trimNew >= -TRIM_MAX) begin
					dirty_d = 1'b1;
					if (cur_q[0])
						set_d.trimHi = trimNew;
					else
						set_d.trimLo = trimNew;
				end
			end
			SCR_RESET: begin
				if (stepCw || stepCcw)
					yes_d = !yes_q;
				if (shortEv[0] || longEv[0])
					goOperate = 1'b1;
				else if (shortEv[1]) begin
					goOperate = 1'b1;
					if (yes_q) begin
						set_d = SETTINGS_DEF;
						dirty_d = 1'b1;
					end
				end
			end
			default: goOperate = 1'b1;
		endcase
		if (idle_q >= 32'(IDLE_CYC - 1) && !activity)
			goOperate = 1'b1;
		if (goOperate) begin
			scr_d = SCR_OPERATE;
			if (dirty_d) begin
				nvmWr_d = 1'b1;
				nvmData_d = set_d;
				dirty_d = 1'b0;
			end
		end
		if (scr_d != scr_q)
			cur_d = 4'h0;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			scr_q <= SCR_OPERATE;
			cur_q <= 4'h0;
			set_q <= SETTINGS_DEF;
			nvmData_q <= SETTINGS_DEF;
			dirty_q <= 1'b0;
			yes_q <= 1'b0;
			nvmWr_q <= 1'b0;
			idle_q <= 32'h0;
		end else begin
			scr_q <= scr_d;
			cur_q <= cur_d;
			set_q <= set_d;
			nvmData_q <= nvmData_d;
			dirty_q <= dirty_d;
			yes_q <= yes_d;
			nvmWr_q <= nvmWr_d;
			idle_q <= idle_d;
		end
	end

	// -------------------------------------------------------------
	// cursor blink and operate display
	// -------------------------------------------------------------
	logic [31:0] blinkCnt_q, blinkCnt_d;
	logic blink_q, blink_d;
	fpmc_opmode_t opMode_q, opMode_d;
	logic [16:0] opFreq_q, opFreq_d;

	always_comb begin
		blinkCnt_d = blinkCnt_q + 32'h1;
		blink_d = blink_q;
		if (blinkCnt_q >= 32'(BLINK_CYC - 1)) begin
			blinkCnt_d = 32'h0;
			blink_d = !blink_q;
		end
		// limits are fixed; the set points only scale the analog output
		opFreq_d = measFreqHz;
		if (measFreqHz < OP_MIN_HZ)
			opMode_d = OP_ZERO;
		else if (measFreqHz > OP_MAX_HZ)
			opMode_d = OP_DASH;
		else
			opMode_d = OP_VALUE;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			blinkCnt_q <= 32'h0;
			blink_q <= 1'b1;
			opMode_q <= OP_ZERO;
			opFreq_q <= 17'h00000;
		end else begin
			blinkCnt_q <= blinkCnt_d;
			blink_q <= blink_d;
			opMode_q <= opMode_d;
			opFreq_q <= opFreq_d;
		end
	end

	// -------------------------------------------------------------
	// ahb-lite register slave, zero wait states
	// -------------------------------------------------------------
	logic wrPend_q, wrPend_d;
	logic [7:0] wrAddr_q, wrAddr_d;
	logic [31:0] ctrl_q, ctrl_d, rdata_q, rdata_d;
	logic accept;

	assign accept = hsel && hready && htrans[1];

	always_comb begin
		wrPend_d = accept && hwrite;
		wrAddr_d = accept ? haddr[7:0] : wrAddr_q;
		ctrl_d = ctrl_q;
		if (wrPend_q && wrAddr_q == REG_CTRL)
			ctrl_d = hwdata & 32'h0000_3FF1;
		rdata_d = 32'h0;
		if (accept && !hwrite) begin
			case (haddr[7:0])
				REG_STATUS: rdata_d = {10'h000, set_q.contrast, 4'h0, opMode_q, dirty_q, yes_q, cur_q, scr_q};
				REG_SETPT: rdata_d = {set_q.fLower, set_q.fUpper};
				REG_CTRL: rdata_d = ctrl_q;
				REG_TRIM: rdata_d = {5'h00, set_q.trimHi, 5'h00, set_q.trimLo};
				default: rdata_d = 32'h0;
			endcase
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wrPend_q <= 1'b0;
			wrAddr_q <= 8'h00;
			ctrl_q <= CTRL_RESET;
			rdata_q <= 32'h0;
		end else begin
			wrPend_q <= wrPend_d;
			wrAddr_q <= wrAddr_d;
			ctrl_q <= ctrl_d;
			rdata_q <= rdata_d;
		end
	end

	// -------------------------------------------------------------
	// outputs
	// -------------------------------------------------------------
	assign hrdata = rdata_q;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign screen = scr_q;
	assign cursor = cur_q;
	assign cursorBlink = blink_q && scr_q != SCR_OPERATE;
	assign resetYes = yes_q;
	assign operMode = opMode_q;
	assign operFreqHz = opFreq_q;
	assign per_rev_filter_indicator = ctrl_q[0];
	assign perRevCount = ctrl_q[13:4];
	assign settings = set_q;
	assign nvmWrite = nvmWr_q;
	assign nvmData = nvmData_q;
endmodule : fpmc_menu_ctrl

// [include/fpmc_pkg.sv]
// constants, types and register map of the front-panel menu controller
// assumes a single 25 MHz clock; panel inputs arrive already synchronous
package fpmc_pkg;
	localparam int CLK_HZ = 25_000_000;
	localparam int CLK_PER_MS = CLK_HZ / 1000;
	localparam int LONG_PRESS_MS = 1000;
	localparam int IDLE_RETURN_MS = 20000;
	localparam int DEBOUNCE_MS = 5;
	localparam int BLINK_MS = 500;
	// -------------------------------------------------------------
	// set-point defaults and limits
	// -------------------------------------------------------------
	localparam logic [15:0] F_UPPER_DEF = 16'hC350;
	localparam logic [15:0] F_LOWER_DEF = 16'h0000;
	localparam logic [17:0] F_UPPER_MIN = 18'h0000A;
	localparam logic [17:0] F_UPPER_MAX = 18'h0C350;
	localparam logic [17:0] F_LOWER_MAX = 18'h0C346;
	localparam logic [17:0] F_GAP = 18'h0000A;
	localparam logic signed [10:0] TRIM_DEF = 11'sh000;
	localparam logic signed [10:0] TRIM_MAX = 11'sh2EE;
	localparam logic [5:0] CONTRAST_DEF = 6'h20;
	localparam logic [5:0] CONTRAST_MAX = 6'h3F;
	localparam logic [3:0] FREQ_LAST_POS = 4'h9;
	localparam logic [3:0] UPPER_DIGITS = 4'h5;
	// fixed operating limits, independent of the set points
	localparam logic [16:0] OP_MIN_HZ = 17'h00001;
	localparam logic [16:0] OP_MAX_HZ = 17'h0F618;
	// -------------------------------------------------------------
	// register map
	// -------------------------------------------------------------
	localparam logic [7:0] REG_STATUS = 8'h00;
	localparam logic [7:0] REG_SETPT = 8'h04;
	localparam logic [7:0] REG_CTRL = 8'h08;
	localparam logic [7:0] REG_TRIM = 8'h0C;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0010;

	typedef enum logic [3:0] {
		SCR_OPERATE = 4'h0, SCR_FREQ = 4'h1, SCR_VOLT = 4'h2, SCR_PULSES = 4'h3,
		SCR_SENS = 4'h4, SCR_BW = 4'h5, SCR_OUTFILT = 4'h6, SCR_CAL = 4'h7,
		SCR_CONTRAST = 4'h8, SCR_ALIGN = 4'h9, SCR_RESET = 4'hA
	} fpmc_screen_t;

	typedef enum logic [1:0] {
		OP_ZERO = 2'b00, OP_VALUE = 2'b01, OP_DASH = 2'b10
	} fpmc_opmode_t;

	typedef struct packed {
		logic [15:0] fUpper;
		logic [15:0] fLower;
		logic signed [10:0] trimLo;
		logic signed [10:0] trimHi;
		logic [5:0] contrast;
	} fpmc_settings_t;

	localparam fpmc_settings_t SETTINGS_DEF = '{F_UPPER_DEF, F_LOWER_DEF, TRIM_DEF, TRIM_DEF, CONTRAST_DEF};
endpackage : fpmc_pkg

// [sim/fpmc_operator.sv]
// operator model: drives the display button and the rotary encoder
// assumes the controller samples the panel lines on the rising clock edge
`timescale 1ns/1ps
module fpmc_operator (
	// clock
	input wire logic clk,
	// panel lines, high while pressed
	output logic dispBtn,
	output logic encBtn,
	output logic encA,
	output logic encB
);
	import fpmc_pkg::*;
	initial begin
		dispBtn = 1'b0;
		encBtn = 1'b0;
		encA = 1'b0;
		encB = 1'b0;
	end
	// a one-cycle contact bounce ahead of the real press must be ignored
	task disp(input int n, input bit bounce);
		if (bounce) begin
			dispBtn <= 1'b1;
			@(posedge clk);
			dispBtn <= 1'b0;
			repeat (4) @(posedge clk);
		end
		dispBtn <= 1'b1;
		repeat (n) @(posedge clk);
		dispBtn <= 1'b0;
		repeat (12) @(posedge clk);
	endtask : disp
	task push(input int n);
		encBtn <= 1'b1;
		repeat (n) @(posedge clk);
		encBtn <= 1'b0;
		repeat (12) @(posedge clk);
	endtask : push
	// direction line settles well before the edge of the stepping line
	task step(input bit cw);
		encB <= !cw;
		repeat (6) @(posedge clk);
		encA <= 1'b1;
		repeat (6) @(posedge clk);
		encA <= 1'b0;
		repeat (6) @(posedge clk);
	endtask : step
endmodule : fpmc_operator

// [sim/fpmc_menu_ctrl_asserts.sv]
// port checker for the menu controller, bound to every instance
// assumes one clock domain and an active-low asynchronous reset
`timescale 1ns/1ps
module fpmc_menu_ctrl_asserts (
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// bus
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	// display and store
	input wire fpmc_pkg::fpmc_screen_t screen,
	input wire logic [3:0] cursor,
	input wire logic cursorBlink,
	input wire logic resetYes,
	input wire fpmc_pkg::fpmc_opmode_t operMode,
	input wire logic [16:0] operFreqHz,
	input wire logic per_rev_filter_indicator,
	input wire logic [9:0] perRevCount,
	input wire fpmc_pkg::fpmc_settings_t settings,
	input wire logic nvmWrite
);
	import fpmc_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	sequence s_ctrl_wr;
		hsel && hready && htrans[1] && hwrite && haddr == 32'h0000_0008 ##1 1'b1;
	endsequence
	sequence s_enter_reset;
		screen == SCR_ALIGN ##1 screen == SCR_RESET;
	endsequence
	property p_ctrl_wr;
		s_ctrl_wr |=> per_rev_filter_indicator == $past(hwdata[0]) && perRevCount == $past(hwdata[13:4]);
	endproperty
	property p_rd_idle;
		!(hsel && hready && htrans[1] && !hwrite) |=> hrdata == 32'h0000_0000;
	endproperty
	property p_bus_ok;
		hreadyout && !hresp;
	endproperty
	property p_nvm_pulse;
		nvmWrite |=> !nvmWrite;
	endproperty
	property p_nvm_op;
		nvmWrite |-> screen == SCR_OPERATE;
	endproperty
	property p_limits;
		settings.fUpper >= F_UPPER_MIN && settings.fUpper <= F_UPPER_MAX && settings.fLower <= F_LOWER_MAX
			&& {2'h0, settings.fUpper} >= {2'h0, settings.fLower} + F_GAP;
	endproperty
	property p_trim;
		$signed(settings.trimLo) <= TRIM_MAX && $signed(settings.trimLo) >= -TRIM_MAX
			&& $signed(settings.trimHi) <= TRIM_MAX && $signed(settings.trimHi) >= -TRIM_MAX;
	endproperty
	property p_cur_zero;
		screen != $past(screen) |-> cursor == 4'h0;
	endproperty
	property p_freq_cur;
		screen == SCR_FREQ |-> cursor <= FREQ_LAST_POS;
	endproperty
	property p_blink;
		screen == SCR_OPERATE |-> !cursorBlink;
	endproperty
	property p_oper;
		operMode == (operFreqHz < OP_MIN_HZ ? OP_ZERO : (operFreqHz > OP_MAX_HZ ? OP_DASH : OP_VALUE));
	endproperty
	property p_reset_entry;
		s_enter_reset |-> !resetYes;
	endproperty
	a_ctrl_wr: assert property (p_ctrl_wr) else $error("ctrl write not applied");
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside read");
	a_bus_ok: assert property (p_bus_ok) else $error("bus answer not okay");
	a_nvm_pulse: assert property (p_nvm_pulse) else $error("store pulse too long");
	a_nvm_op: assert property (p_nvm_op) else $error("store off operate screen");
	a_limits: assert property (p_limits) else $error("set point out of limits");
	a_trim: assert property (p_trim) else $error("trim out of limits");
	a_cur_zero: assert property (p_cur_zero) else $error("cursor not home on entry");
	a_freq_cur: assert property (p_freq_cur) else $error("frequency cursor past end");
	a_blink: assert property (p_blink) else $error("blink on operate screen");
	a_oper: assert property (p_oper) else $error("operate mode wrong");
	a_reset_entry: assert property (p_reset_entry) else $error("reset screen opens on yes");
endmodule : fpmc_menu_ctrl_asserts
bind fpmc_menu_ctrl fpmc_menu_ctrl_asserts chk_u (.clk, .resetn, .hsel, .haddr, .htrans, .hwrite, .hwdata,
	.hready, .hrdata, .hreadyout, .hresp, .screen, .cursor, .cursorBlink, .resetYes, .operMode, .operFreqHz,
	.per_rev_filter_indicator, .perRevCount, .settings, .nvmWrite);

// [sim/tb_front_panel_menu_controller.sv]
// self-checking bench for the menu controller with an operator model
// assumes shortened counts: long press 20, idle 200, debounce 3 cycles
`timescale 1ns/1ps
module tb_front_panel_menu_controller;
	import fpmc_pkg::*;
	logic clk, resetn, hsel, hwrite;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [16:0] measFreqHz, operFreqHz;
	wire logic hready;
	logic hreadyout, hresp, dispBtn, encBtn, encA, encB, cursorBlink, resetYes, perRev, nvmWrite;
	logic [3:0] cursor;
	logic [9:0] perRevCount;
	fpmc_screen_t screen;
	fpmc_opmode_t operMode;
	fpmc_settings_t settings, nvmData, expSet;
	int mismatches = 0, n_compared = 0, nvmCount = 0, n0;
	logic [16:0] fTab [4] = '{17'h00000, 17'h00001, 17'h0F618, 17'h0F619};
	fpmc_opmode_t mTab [4] = '{OP_ZERO, OP_VALUE, OP_VALUE, OP_DASH};
	assign hready = hreadyout;
	fpmc_menu_ctrl #(.LONG_CYC(20), .IDLE_CYC(200), .DEBOUNCE_CYC(3), .BLINK_CYC(8)) dut_u (.clk, .resetn,
		.hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .dispBtn,
		.encBtn, .encA, .encB, .measFreqHz, .screen, .cursor, .cursorBlink, .resetYes, .operMode, .operFreqHz,
		.per_rev_filter_indicator(perRev), .perRevCount, .settings, .nvmWrite, .nvmData);
	fpmc_operator op_u (.clk, .dispBtn, .encBtn, .encA, .encB);
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) if (nvmWrite === 1'b1) nvmCount <= nvmCount + 1;
	task chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		n_compared++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask : chk
	task finish_test;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : finish_test
	// one single transfer; the wait ends only on hready, the watchdog cuts a hang
	task ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= wr;
		htrans <= 2'b10;
		do @(posedge clk); while (hready !== 1'b1);
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
		rd = hrdata;
	endtask : ahb
	task t_bus;
		ahb(1'b0, 32'h00, 32'h0);
		chk("status", rd, 32'h0020_0000);
		ahb(1'b0, 32'h04, 32'h0);
		chk("setpt", rd, 32'h0000_C350);
		ahb(1'b1, 32'h04, 32'h1234_5678);
		ahb(1'b0, 32'h04, 32'h0);
		chk("setpt ro", rd, 32'h0000_C350);
		ahb(1'b1, 32'h08, 32'h0000_0961);
		ahb(1'b0, 32'h08, 32'h0);
		chk("ctrl", rd, 32'h0000_0961);
		chk("perRev", {perRev, perRevCount}, 11'h496);
		ahb(1'b0, 32'h40, 32'h0);
		chk("unmapped", rd, 32'h0);
		ahb(1'b0, 32'h0C, 32'h0);
		chk("trim", rd, 32'h0);
	endtask : t_bus
	task t_oper;
		for (int i = 0; i < 4; i++) begin
			measFreqHz <= fTab[i];
			repeat (3) @(posedge clk);
			chk("operMode", operMode, mTab[i]);
			chk("operFreq", operFreqHz, fTab[i]);
		end
	endtask : t_oper
	task t_nav;
		op_u.disp(8, 1'b1);
		chk("screen", screen, SCR_FREQ);
		for (int i = 2; i <= 8; i++) begin
			op_u.disp(8, 1'b0);
			chk("ring", screen, i % 8);
		end
		chk("no store", nvmCount, 0);
	endtask : t_nav
	task t_freq;
		op_u.disp(8, 1'b0);
		chk("cursor", cursor, 4'h0);
		n0 = cursorBlink;
		repeat (8) @(posedge clk);
		chk("blink", cursorBlink, !n0[0]);
		op_u.step(1'b1);
		chk("upper max", settings.fUpper, 16'hC350);
		op_u.step(1'b0);
		chk("upper", settings.fUpper, 16'h9C40);
		repeat (5) op_u.push(8);
		chk("cursor", cursor, 4'h5);
		repeat (4) op_u.step(1'b1);
		chk("gap", settings.fLower, 16'h7530);
		repeat (4) op_u.push(8);
		op_u.step(1'b0);
		chk("borrow", settings.fLower, 16'h752F);
		op_u.push(8);
		chk("wrap", cursor, 4'h0);
		chk("no store", nvmCount, 0);
		repeat (260) @(posedge clk);
		chk("idle", screen, SCR_OPERATE);
		chk("store", nvmCount, 1);
		expSet = '{16'h9C40, 16'h752F, TRIM_DEF, TRIM_DEF, CONTRAST_DEF};
		chk("nvmData", nvmData, expSet);
	endtask : t_freq
	task t_contrast;
		op_u.disp(40, 1'b0);
		chk("long", screen, SCR_CONTRAST);
		op_u.step(1'b1);
		chk("darker", settings.contrast, 6'h21);
		repeat (2) op_u.step(1'b0);
		chk("lighter", settings.contrast, 6'h1F);
		op_u.disp(40, 1'b0);
		chk("long back", screen, SCR_OPERATE);
		op_u.disp(40, 1'b0);
		repeat (2) op_u.disp(8, 1'b0);
		chk("two shorts", screen, SCR_OPERATE);
	endtask : t_contrast
	task t_factory;
		op_u.disp(40, 1'b0);
		op_u.disp(8, 1'b0);
		chk("align", screen, SCR_ALIGN);
		op_u.step(1'b1);
		chk("trimLo", settings.trimLo, 11'sh001);
		op_u.push(8);
		chk("cursor hi", cursor, 4'h1);
		op_u.step(1'b0);
		chk("trimHi", settings.trimHi, 11'sh7FF);
		op_u.push(40);
		chk("reset scr", {screen, resetYes}, {SCR_RESET, 1'b0});
		op_u.step(1'b1);
		chk("yes", resetYes, 1'b1);
		n0 = nvmCount;
		op_u.push(8);
		chk("back", screen, SCR_OPERATE);
		chk("defaults", settings, SETTINGS_DEF);
		chk("stored", nvmCount - n0, 1);
		chk("nvmData", nvmData, SETTINGS_DEF);
	endtask : t_factory
	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		finish_test;
	end
	initial begin
		resetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		measFreqHz = 17'h0;
		repeat (5) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		chk("power up", {screen, cursor}, {SCR_OPERATE, 4'h0});
		chk("settings", settings, SETTINGS_DEF);
		t_bus;
		t_oper;
		t_nav;
		t_freq;
		t_contrast;
		t_factory;
		finish_test;
	end
endmodule : tb_front_panel_menu_controller
